// file: core/bmss_pkg.sv
package bmss_pkg;
    // ------------------------------------------------------------
    // launch methods
    // ------------------------------------------------------------
    localparam logic [1:0] LAUNCH_PARK1 = 2'h0;
    localparam logic [1:0] LAUNCH_PARK2 = 2'h1;
    localparam logic [1:0] LAUNCH_PROBE = 2'h2;
    localparam logic [1:0] LAUNCH_SLOW = 2'h3;
    // ------------------------------------------------------------
    // gate bit order {hs_a,hs_b,hs_c,ls_a,ls_b,ls_c}
    // ------------------------------------------------------------
    localparam logic [5:0] GATE_OFF = 6'h00;
    localparam logic [5:0] GATE_ALL_HS = 6'h38;
    localparam logic [5:0] GATE_ALL_LS = 6'h07;
    localparam logic [5:0] GATE_PARK_CB = 6'h0a; // hs_c + ls_b
    localparam logic [5:0] GATE_PARK_FWD2 = 6'h0c; // hs_c + ls_a
    // probe patterns: hs of first letter, ls of second
    localparam logic [5:0] PROBE_BC = 6'h11;
    localparam logic [5:0] PROBE_CB = 6'h0a;
    localparam logic [5:0] PROBE_AB = 6'h22;
    localparam logic [5:0] PROBE_BA = 6'h14;
    localparam logic [5:0] PROBE_CA = 6'h0c;
    localparam logic [5:0] PROBE_AC = 6'h21;
    localparam logic [5:0] LS_MASK = 6'h07;
    localparam logic [2:0] PROBE_LAST = 3'h5;
    localparam logic [8:0] DEG_FULL = 9'h168; // 360 degrees
    localparam logic [8:0] DEG_STEP = 9'h03c; // 60 degrees per probe slot
    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_SENSE = 4'h1,
        ST_COAST = 4'h2,
        ST_BRAKE = 4'h3,
        ST_LAUNCH = 4'h4,
        ST_PARK = 4'h5,
        ST_PROBE = 4'h6,
        ST_PROBE_GAP = 4'h7,
        ST_OPEN = 4'h8,
        ST_CLOSED = 4'h9,
        ST_REV_LOCK = 4'ha,
        ST_REV_DECEL = 4'hb
    } bmss_state_t;
endpackage

// file: core/bmss_seq.sv
module bmss_seq #(
    parameter int TW = 16,
    parameter int DW = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // command and configuration
    input wire logic run_request,
    input wire logic initial_motion_sense_enable,
    input wire logic rejoin_spinning_enable,
    input wire logic counter_rotation_drive_enable,
    input wire logic coast_enable,
    input wire logic brake_enable,
    input wire logic stop_clamp_side_select,
    input wire logic [TW-1:0] stop_clamp_duration,
    input wire logic [TW-1:0] coast_duration,
    input wire logic [1:0] launch_method_select,
    input wire logic [TW-1:0] dc_park_duration,
    input wire logic [DW-1:0] dc_park_duty,
    input wire logic [DW-1:0] dc_park_ramp_step,
    input wire logic probe_release_select,
    input wire logic [TW-1:0] probe_gap_duration,
    input wire logic [8:0] probe_drive_offset,
    // phase sensing from the analog front end
    input wire logic sense_done,
    input wire logic sense_spinning,
    input wire logic sense_reverse,
    input wire logic [8:0] sense_angle,
    input wire logic rev_speed_low,
    input wire logic rev_speed_zero,
    input wire logic current_over_park_limit,
    input wire logic current_over_probe_threshold,
    input wire logic open_loop_handoff_reached,
    input wire logic back_emf_commutate,
    // drive outputs
    output logic [5:0] gate_on,
    output logic [DW-1:0] drive_duty,
    output logic sense_active,
    output logic open_loop_active,
    output logic open_loop_reverse,
    output logic closed_loop_active,
    output logic slow_first_cycle_start,
    output logic [8:0] drive_angle,
    output logic [2:0] probe_winner,
    output logic [TW-1:0] probe_winner_time
);
    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    bmss_pkg::bmss_state_t state_reg, state_next;
    logic [TW-1:0] timer_reg, timer_next;
    logic [5:0] gate_reg, gate_next;
    logic [DW-1:0] duty_reg, duty_next;
    logic second_park_reg, second_park_next;
    logic [2:0] probe_idx_reg, probe_idx_next;
    logic [2:0] best_idx_reg, best_idx_next;
    logic [TW-1:0] best_time_reg, best_time_next;
    logic [8:0] angle_reg, angle_next;
    logic [2:0] comm_step_reg, comm_step_next;
    logic rev_reg, rev_next;
    logic sfc_reg, sfc_next;
    logic [5:0] probe_pattern;
    logic [DW:0] duty_sum;
    logic [9:0] angle_sum;
    logic [8:0] probe_angle;

    always_comb
    begin
        case (probe_idx_reg)
            3'h0: probe_pattern = bmss_pkg::PROBE_BC;
            3'h1: probe_pattern = bmss_pkg::PROBE_CB;
            3'h2: probe_pattern = bmss_pkg::PROBE_AB;
            3'h3: probe_pattern = bmss_pkg::PROBE_BA;
            3'h4: probe_pattern = bmss_pkg::PROBE_CA;
            default: probe_pattern = bmss_pkg::PROBE_AC;
        endcase
    end

    // probe pattern is 60 degrees per probe slot, so angle = slot * 60
    assign probe_angle = 9'(best_idx_reg * bmss_pkg::DEG_STEP);
    assign duty_sum = {1'b0, duty_reg} + {1'b0, dc_park_ramp_step};
    assign angle_sum = {1'b0, probe_angle} + {1'b0, probe_drive_offset};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        timer_next = timer_reg + TW'(1);
        gate_next = gate_reg;
        duty_next = duty_reg;
        second_park_next = second_park_reg;
        probe_idx_next = probe_idx_reg;
        best_idx_next = best_idx_reg;
        best_time_next = best_time_reg;
        angle_next = angle_reg;
        comm_step_next = comm_step_reg;
        rev_next = rev_reg;
        sfc_next = 1'b0;
        case (state_reg)
            bmss_pkg::ST_IDLE:
            begin
                gate_next = bmss_pkg::GATE_OFF;
                duty_next = '0;
                timer_next = '0;
                rev_next = 1'b0;
                if (run_request)
                begin
                    if (initial_motion_sense_enable)
                        state_next = bmss_pkg::ST_SENSE;
                    else if (brake_enable)
                        state_next = bmss_pkg::ST_BRAKE;
                    else
                        state_next = bmss_pkg::ST_LAUNCH;
                end
            end
            bmss_pkg::ST_SENSE:
            begin
                timer_next = '0;
                if (sense_done)
                begin
                    if (!sense_spinning)
                        state_next = brake_enable ? bmss_pkg::ST_BRAKE : bmss_pkg::ST_LAUNCH;
                    else if (!sense_reverse && rejoin_spinning_enable)
                    begin
                        angle_next = sense_angle;
                        state_next = bmss_pkg::ST_CLOSED;
                    end
                    else if (sense_reverse && counter_rotation_drive_enable)
                        state_next = bmss_pkg::ST_REV_LOCK;
                    else if (coast_enable)
                        state_next = bmss_pkg::ST_COAST;
                    else
                        state_next = brake_enable ? bmss_pkg::ST_BRAKE : bmss_pkg::ST_LAUNCH;
                end
            end
            bmss_pkg::ST_COAST:
            begin
                gate_next = bmss_pkg::GATE_OFF;
                if (timer_reg >= coast_duration)
                begin
                    timer_next = '0;
                    state_next = brake_enable ? bmss_pkg::ST_BRAKE : bmss_pkg::ST_LAUNCH;
                end
            end
            bmss_pkg::ST_BRAKE:
            begin
                gate_next = stop_clamp_side_select ? bmss_pkg::GATE_ALL_HS
                                                   : bmss_pkg::GATE_ALL_LS;
                if (timer_reg >= stop_clamp_duration)
                begin
                    timer_next = '0;
                    gate_next = bmss_pkg::GATE_OFF;
                    state_next = bmss_pkg::ST_LAUNCH;
                end
            end
            bmss_pkg::ST_LAUNCH:
            begin
                timer_next = '0;
                duty_next = '0;
                second_park_next = 1'b0;
                probe_idx_next = '0;
                best_idx_next = '0;
                best_time_next = '1;
                case (launch_method_select)
                    bmss_pkg::LAUNCH_PARK1, bmss_pkg::LAUNCH_PARK2:
                        state_next = bmss_pkg::ST_PARK;
                    bmss_pkg::LAUNCH_PROBE:
                        state_next = bmss_pkg::ST_PROBE;
                    default:
                    begin
                        sfc_next = 1'b1;
                        angle_next = '0;
                        state_next = bmss_pkg::ST_OPEN;
                    end
                endcase
            end
            bmss_pkg::ST_PARK:
            begin
                gate_next = second_park_reg ? bmss_pkg::GATE_PARK_FWD2
                                            : bmss_pkg::GATE_PARK_CB;
                // limiter holds duty rather than chopping the pattern
                if (current_over_park_limit)
                    duty_next = duty_reg;
                else if (duty_sum >= {1'b0, dc_park_duty})
                    duty_next = dc_park_duty;
                else
                    duty_next = duty_sum[DW-1:0];
                if (timer_reg >= dc_park_duration)
                begin
                    timer_next = '0;
                    duty_next = '0;
                    if (launch_method_select == bmss_pkg::LAUNCH_PARK2 && !second_park_reg)
                        second_park_next = 1'b1;
                    else
                    begin
                        angle_next = second_park_reg ? bmss_pkg::DEG_STEP : '0;
                        state_next = bmss_pkg::ST_OPEN;
                    end
                end
            end
            bmss_pkg::ST_PROBE:
            begin
                gate_next = probe_pattern;
                if (current_over_probe_threshold)
                begin
                    gate_next = probe_release_select ? bmss_pkg::GATE_OFF
                                                     : (probe_pattern & bmss_pkg::LS_MASK);
                    if (timer_reg < best_time_reg)
                    begin
                        best_time_next = timer_reg;
                        best_idx_next = probe_idx_reg;
                    end
                    timer_next = '0;
                    state_next = bmss_pkg::ST_PROBE_GAP;
                end
            end
            bmss_pkg::ST_PROBE_GAP:
            begin
                // gap length is the pulse rate; software sets it for decay
                if (timer_reg >= probe_gap_duration)
                begin
                    timer_next = '0;
                    gate_next = bmss_pkg::GATE_OFF;
                    if (probe_idx_reg == bmss_pkg::PROBE_LAST)
                        state_next = bmss_pkg::ST_OPEN;
                    else
                    begin
                        probe_idx_next = probe_idx_reg + 3'h1;
                        state_next = bmss_pkg::ST_PROBE;
                    end
                    if (probe_idx_reg == bmss_pkg::PROBE_LAST)
                        angle_next = (angle_sum >= {1'b0, bmss_pkg::DEG_FULL})
                            ? 9'(angle_sum - {1'b0, bmss_pkg::DEG_FULL})
                            : angle_sum[8:0];
                end
            end
            bmss_pkg::ST_REV_LOCK:
            begin
                rev_next = 1'b1;
                if (rev_speed_low)
                    state_next = bmss_pkg::ST_REV_DECEL;
            end
            bmss_pkg::ST_REV_DECEL:
            begin
                if (rev_speed_zero)
                begin
                    rev_next = 1'b0;
                    angle_next = sense_angle;
                    state_next = bmss_pkg::ST_OPEN;
                end
            end
            bmss_pkg::ST_OPEN:
            begin
                // handoff to closed loop in the forward direction only; reverse drive ends in ST_REV_DECEL
                gate_next = bmss_pkg::GATE_OFF;
                if (open_loop_handoff_reached)
                    state_next = bmss_pkg::ST_CLOSED;
            end
            bmss_pkg::ST_CLOSED:
            begin
                if (back_emf_commutate)
                    comm_step_next = (comm_step_reg == bmss_pkg::PROBE_LAST)
                        ? 3'h0 : comm_step_reg + 3'h1;
                if (!run_request)
                    state_next = bmss_pkg::ST_IDLE;
            end
            default:
                state_next = bmss_pkg::ST_IDLE;
        endcase
        if (!run_request && state_reg != bmss_pkg::ST_CLOSED)
            state_next = bmss_pkg::ST_IDLE;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_reg <= bmss_pkg::ST_IDLE;
            timer_reg <= '0;
            gate_reg <= bmss_pkg::GATE_OFF;
            duty_reg <= '0;
            second_park_reg <= 1'b0;
            probe_idx_reg <= '0;
            best_idx_reg <= '0;
            best_time_reg <= '1;
            angle_reg <= '0;
            comm_step_reg <= '0;
            rev_reg <= 1'b0;
            sfc_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            gate_reg <= gate_next;
            duty_reg <= duty_next;
            second_park_reg <= second_park_next;
            probe_idx_reg <= probe_idx_next;
            best_idx_reg <= best_idx_next;
            best_time_reg <= best_time_next;
            angle_reg <= angle_next;
            comm_step_reg <= comm_step_next;
            rev_reg <= rev_next;
            sfc_reg <= sfc_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // closed-loop gating belongs to the commutation block downstream
    logic sense_q, open_q, closed_q;
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sense_q <= 1'b0;
            open_q <= 1'b0;
            closed_q <= 1'b0;
        end
        else
        begin
            sense_q <= state_next == bmss_pkg::ST_SENSE;
            open_q <= state_next == bmss_pkg::ST_OPEN || state_next == bmss_pkg::ST_REV_LOCK
                || state_next == bmss_pkg::ST_REV_DECEL;
            closed_q <= state_next == bmss_pkg::ST_CLOSED;
        end
    end

    assign gate_on = gate_reg;
    assign drive_duty = duty_reg;
    assign sense_active = sense_q;
    assign open_loop_active = open_q;
    assign open_loop_reverse = rev_reg;
    assign closed_loop_active = closed_q;
    assign slow_first_cycle_start = sfc_reg;
    assign drive_angle = angle_reg;
    assign probe_winner = best_idx_reg;
    assign probe_winner_time = best_time_reg;
endmodule

// file: tb/bmss_motor_model.sv
module bmss_motor_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // drive side
    input wire logic [5:0] gate_on,
    input wire logic [7:0] drive_duty,
    input wire logic sense_active,
    input wire logic open_loop_active,
    input wire logic open_loop_reverse,
    // motor setup
    input wire logic [1:0] spin_mode,
    input wire logic [5:0][7:0] rise_time,
    input wire logic [7:0] park_limit,
    // sensed motor
    output logic sense_done,
    output logic sense_spinning,
    output logic sense_reverse,
    output logic [8:0] sense_angle,
    output logic rev_speed_low,
    output logic rev_speed_zero,
    output logic current_over_park_limit,
    output logic current_over_probe_threshold,
    output logic open_loop_handoff_reached,
    output logic back_emf_commutate
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [5:0][5:0] PAT = {bmss_pkg::PROBE_AC, bmss_pkg::PROBE_CA, bmss_pkg::PROBE_BA,
        bmss_pkg::PROBE_AB, bmss_pkg::PROBE_CB, bmss_pkg::PROBE_BC};
    logic [7:0] probe_cnt;
    logic [7:0] run_cnt;
    logic [2:0] idx;
    logic hit;
    always_comb
    begin
        hit = 1'b0;
        idx = 3'h0;
        for (int i = 0; i < 6; i++)
            if (gate_on == PAT[i])
            begin
                hit = 1'b1;
                idx = 3'(i);
            end
    end
    // current restarts from zero once a pattern is released
    always_ff @(posedge clock)
    begin
        probe_cnt <= (rst || !hit) ? 8'h00 : probe_cnt + 8'h01;
        run_cnt <= (rst || !(sense_active || open_loop_active || open_loop_reverse)) ? 8'h00 :
            run_cnt + 8'h01;
        back_emf_commutate <= rst ? 1'b0 : !back_emf_commutate;
    end
    assign current_over_probe_threshold = hit && probe_cnt >= rise_time[idx];
    assign current_over_park_limit = drive_duty >= park_limit;
    assign sense_done = sense_active && run_cnt == 8'h03;
    assign sense_spinning = spin_mode != 2'h0;
    assign sense_reverse = spin_mode == 2'h2;
    assign sense_angle = 9'h078;
    assign rev_speed_low = open_loop_reverse && run_cnt >= 8'h05;
    assign rev_speed_zero = open_loop_reverse && run_cnt >= 8'h0a;
    assign open_loop_handoff_reached = open_loop_active && !open_loop_reverse && run_cnt >= 8'h08;
endmodule

// file: tb/bmss_seq_chk.sv
module bmss_seq_chk #(
    parameter int TW = 16,
    parameter int DW = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // configuration and probe current flag
    input wire logic initial_motion_sense_enable,
    input wire logic rejoin_spinning_enable,
    input wire logic counter_rotation_drive_enable,
    input wire logic stop_clamp_side_select,
    input wire logic [1:0] launch_method_select,
    input wire logic [DW-1:0] dc_park_duty,
    input wire logic [DW-1:0] dc_park_ramp_step,
    input wire logic probe_release_select,
    input wire logic current_over_probe_threshold,
    // drive outputs
    input wire logic [5:0] gate_on,
    input wire logic [DW-1:0] drive_duty,
    input wire logic sense_active,
    input wire logic open_loop_active,
    input wire logic open_loop_reverse,
    input wire logic closed_loop_active,
    input wire logic slow_first_cycle_start
);
    // ----
    // helpers
    // ----
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    logic probe_on;
    logic park_on;
    // park and probe share patterns, so the method tells them apart
    assign probe_on = launch_method_select == bmss_pkg::LAUNCH_PROBE && gate_on[5:3] != 3'h0;
    assign park_on = launch_method_select[1] == 1'b0 && gate_on != bmss_pkg::GATE_OFF;
    sequence s_probe_hit;
        probe_on && current_over_probe_threshold;
    endsequence
    // ----
    // properties
    // ----
    a_no_shoot_through: assert property ((gate_on[5:3] & gate_on[2:0]) == 3'h0)
        else $error("phase shoot-through");
    a_brake_high_side: assert property (gate_on == bmss_pkg::GATE_ALL_HS |-> stop_clamp_side_select)
        else $error("wrong clamp side");
    a_brake_low_side: assert property (gate_on == bmss_pkg::GATE_ALL_LS |-> !stop_clamp_side_select)
        else $error("wrong clamp side");
    a_sense_skipped: assert property (!initial_motion_sense_enable |-> !sense_active)
        else $error("sensing while disabled");
    a_hiz_release: assert property (s_probe_hit ##0 probe_release_select |-> ##[1:3] gate_on == bmss_pkg::GATE_OFF)
        else $error("probe not released");
    a_recirc_release: assert property (s_probe_hit ##0 !probe_release_select |->
        ##[1:3] (gate_on[5:3] == 3'h0 && gate_on[2:0] != 3'h0))
        else $error("low side not kept");
    a_park_duty_cap: assert property (park_on |-> drive_duty <= dc_park_duty)
        else $error("park duty above target");
    a_park_ramp_step: assert property (park_on && $past(park_on) |->
        {1'b0, drive_duty} <= {1'b0, $past(drive_duty)} + {1'b0, dc_park_ramp_step})
        else $error("park duty step too big");
    a_slow_one_shot: assert property (slow_first_cycle_start |=> !slow_first_cycle_start)
        else $error("slow start pulse too long");
    a_slow_method: assert property (slow_first_cycle_start |-> launch_method_select == bmss_pkg::LAUNCH_SLOW)
        else $error("slow start with another method");
    a_rejoin_gate: assert property ($rose(closed_loop_active) && !$past(open_loop_active) |->
        rejoin_spinning_enable && initial_motion_sense_enable)
        else $error("closed loop without rejoin");
    a_reverse_gate: assert property (open_loop_reverse |->
        counter_rotation_drive_enable && initial_motion_sense_enable)
        else $error("counter drive while disabled");
endmodule

// file: tb/bmss_seq_tb.sv
module bmss_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst, run_request, initial_motion_sense_enable, rejoin_spinning_enable;
    logic counter_rotation_drive_enable, coast_enable, brake_enable, stop_clamp_side_select;
    logic probe_release_select, sense_done, sense_spinning, sense_reverse, rev_speed_low;
    logic rev_speed_zero, current_over_park_limit, current_over_probe_threshold;
    logic open_loop_handoff_reached, back_emf_commutate, sense_active, open_loop_active;
    logic open_loop_reverse, closed_loop_active, slow_first_cycle_start;
    logic [15:0] stop_clamp_duration, coast_duration, dc_park_duration, probe_gap_duration;
    logic [15:0] probe_winner_time;
    logic [7:0] dc_park_duty, dc_park_ramp_step, drive_duty, park_limit;
    logic [8:0] probe_drive_offset, sense_angle, drive_angle, open_angle;
    logic [5:0] gate_on;
    logic [2:0] probe_winner, open_winner;
    logic [1:0] launch_method_select, spin_mode;
    logic [5:0][7:0] rise_time;
    logic saw_hs, saw_ls, saw_slow, saw_rev, saw_open;
    int failures, num_checks, cycles, n_cb, n_fwd2, n_test;
    logic [5:0] probe_seq[$];
    logic [5:0] probe_exp[6] = '{bmss_pkg::PROBE_BC, bmss_pkg::PROBE_CB, bmss_pkg::PROBE_AB,
        bmss_pkg::PROBE_BA, bmss_pkg::PROBE_CA, bmss_pkg::PROBE_AC};
    bmss_seq bmss_seq_inst (
        .clock, .rst, .run_request, .initial_motion_sense_enable, .rejoin_spinning_enable,
        .counter_rotation_drive_enable, .coast_enable, .brake_enable, .stop_clamp_side_select,
        .stop_clamp_duration, .coast_duration, .launch_method_select, .dc_park_duration,
        .dc_park_duty, .dc_park_ramp_step, .probe_release_select, .probe_gap_duration,
        .probe_drive_offset, .sense_done, .sense_spinning, .sense_reverse, .sense_angle,
        .rev_speed_low, .rev_speed_zero, .current_over_park_limit, .current_over_probe_threshold,
        .open_loop_handoff_reached, .back_emf_commutate, .gate_on, .drive_duty, .sense_active,
        .open_loop_active, .open_loop_reverse, .closed_loop_active, .slow_first_cycle_start,
        .drive_angle, .probe_winner, .probe_winner_time);
    bmss_motor_model bmss_motor_model_inst (
        .clock, .rst, .gate_on, .drive_duty, .sense_active, .open_loop_active, .open_loop_reverse,
        .spin_mode, .rise_time, .park_limit, .sense_done, .sense_spinning, .sense_reverse,
        .sense_angle, .rev_speed_low, .rev_speed_zero, .current_over_park_limit,
        .current_over_probe_threshold, .open_loop_handoff_reached, .back_emf_commutate);
    // ----
    // clock, watchdog and monitor
    // ----
    always #5 clock = !clock;
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            end_of_test();
        end
        if (!rst)
        begin
            saw_hs |= gate_on == bmss_pkg::GATE_ALL_HS;
            saw_ls |= gate_on == bmss_pkg::GATE_ALL_LS;
            saw_slow |= slow_first_cycle_start;
            saw_rev |= open_loop_reverse;
            if (launch_method_select != bmss_pkg::LAUNCH_PROBE)
            begin
                n_cb += int'(gate_on == bmss_pkg::GATE_PARK_CB);
                n_fwd2 += int'(gate_on == bmss_pkg::GATE_PARK_FWD2);
            end
            else if (gate_on[5:3] != 3'h0 && (probe_seq.size() == 0 || probe_seq[$] != gate_on))
                probe_seq.push_back(gate_on);
            if (open_loop_active && !open_loop_reverse)
            begin
                saw_open = 1'b1;
                open_angle = drive_angle;
                open_winner = probe_winner;
            end
        end
    end
    // ----
    // tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // f is {sense, rejoin, counter drive, brake, clamp side}
    task automatic go(input logic [1:0] m, input logic [1:0] sp, input logic [4:0] f);
        @(posedge clock);
        #1;
        rst = 1'b1;
        run_request = 1'b0;
        launch_method_select = m;
        spin_mode = sp;
        {initial_motion_sense_enable, rejoin_spinning_enable, counter_rotation_drive_enable,
            brake_enable, stop_clamp_side_select} = f;
        repeat (2) @(posedge clock);
        #1;
        rst = 1'b0;
        {saw_hs, saw_ls, saw_slow, saw_rev, saw_open} = 5'h00;
        n_cb = 0;
        n_fwd2 = 0;
        probe_seq.delete();
        check(gate_on, 6'h00);
        check(probe_winner_time, 16'hffff);
        run_request = 1'b1;
        for (int i = 0; i < 3000 && closed_loop_active !== 1'b1; i++)
        begin
            @(posedge clock);
            #1;
        end
        check(closed_loop_active, 1'b1);
    endtask
    task automatic tdone();
        n_test++;
        $display("test %0d done", n_test);
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----
    // tests
    // ----
    initial
    begin
        {clock, rst, run_request, coast_enable, probe_release_select} = 5'h08;
        {failures, num_checks, cycles, n_test} = '0;
        stop_clamp_duration = 16'h0005;
        coast_duration = 16'h0006;
        dc_park_duration = 16'h0005;
        probe_gap_duration = 16'h0004;
        dc_park_duty = 8'h40;
        dc_park_ramp_step = 8'h10;
        park_limit = 8'h30;
        probe_drive_offset = 9'h14a;
        // CB and BA tie for fastest so the earlier one must win
        rise_time = {8'h0a, 8'h0c, 8'h04, 8'h07, 8'h04, 8'h09};
        go(bmss_pkg::LAUNCH_PARK1, 2'h1, 5'h0b);
        check(saw_hs, 1'b1);
        check(saw_ls, 1'b0);
        check(saw_open, 1'b1);
        check(n_cb, 6);
        check(n_fwd2, 0);
        check(open_angle, 9'h000);
        tdone();
        go(bmss_pkg::LAUNCH_PARK2, 2'h0, 5'h02);
        check(saw_ls, 1'b1);
        check(n_cb, 6);
        check(n_fwd2, 6);
        check(open_angle, 9'h03c);
        tdone();
        for (int s = 0; s < 2; s++)
        begin
            probe_release_select = s[0];
            go(bmss_pkg::LAUNCH_PROBE, 2'h0, 5'h00);
            check(probe_seq.size(), 6);
            for (int i = 0; i < 6; i++)
                check(probe_seq[i], probe_exp[i]);
            check(open_winner, 3'h1);
            check(probe_winner_time, 16'h0005);
            check(open_angle, 9'h01e);
            check(saw_ls, 1'b0);
            tdone();
        end
        go(bmss_pkg::LAUNCH_SLOW, 2'h0, 5'h00);
        check(saw_slow, 1'b1);
        check(saw_open, 1'b1);
        tdone();
        go(bmss_pkg::LAUNCH_PARK1, 2'h1, 5'h18);
        check(saw_open, 1'b0);
        check(n_cb, 0);
        tdone();
        coast_enable = 1'b1;
        go(bmss_pkg::LAUNCH_PARK1, 2'h1, 5'h10);
        check(n_cb, 6);
        check(saw_open, 1'b1);
        coast_enable = 1'b0;
        tdone();
        go(bmss_pkg::LAUNCH_PARK1, 2'h2, 5'h14);
        check(saw_rev, 1'b1);
        check(saw_open, 1'b1);
        tdone();
        go(bmss_pkg::LAUNCH_PARK1, 2'h2, 5'h10);
        check(saw_rev, 1'b0);
        check(n_cb, 6);
        tdone();
        end_of_test();
    end
endmodule
bind bmss_seq bmss_seq_chk #(.TW(TW), .DW(DW)) bmss_seq_chk_inst (
    .clock, .rst, .initial_motion_sense_enable, .rejoin_spinning_enable,
    .counter_rotation_drive_enable, .stop_clamp_side_select, .launch_method_select,
    .dc_park_duty, .dc_park_ramp_step, .probe_release_select, .current_over_probe_threshold,
    .gate_on, .drive_duty, .sense_active, .open_loop_active, .open_loop_reverse,
    .closed_loop_active, .slow_first_cycle_start);
